// [inc/compute_field_map.svh]
// field positions and restricted bank bases of the compute field decoder
`ifndef COMPUTE_FIELD_MAP_SVH
`define COMPUTE_FIELD_MAP_SVH

`define CF_W 20
`define SEL_W 4
`define RSEL_W 2
`define F_TOP_LSB 16
`define F_MID_LSB 12
`define F_HI_LSB 8
`define F_X_LSB 4
`define F_Y_LSB 0
`define RS_MUL_X_LSB 6
`define RS_MUL_Y_LSB 4
`define RS_ALU_X_LSB 2
`define RS_ALU_Y_LSB 0
`define BASE_MUL_X 4'h0
`define BASE_MUL_Y 4'h4
`define BASE_ALU_X 4'h8
`define BASE_ALU_Y 4'hC
`define IDX_ZERO 4'h0

`endif

// [inc/compute_field_pkg.sv]
// types of the compute field decoder
`default_nettype none
package compute_field_pkg;

	// instruction form, one-hot
	typedef enum logic [5:0] {
		FORM_SINGLE = 6'h01,
		FORM_DUAL = 6'h02,
		FORM_MUL_ALU = 6'h04,
		FORM_MUL_DUAL = 6'h08,
		FORM_SHORT = 6'h10,
		FORM_DBL = 6'h20
	} form_t;

endpackage
`default_nettype wire

// [hw/pair_select.sv]
// 64-bit register pair selector check
`timescale 1ns/1ps
`default_nettype none
module pair_select
(
	// selector from the field
	input wire logic [3:0] code,
	// pair low register and validity
	output logic [3:0] low_reg,
	output logic ok
);
	// only even codes name a pair
	assign low_reg = code;
	assign ok = ~code[0];
endmodule
`default_nettype wire

// [hw/compute_field_decode.sv]
// register selector decoder for the compute field of an instruction
//
// Notes on behaviour
// - single computation: result 11:8, X source 7:4, Y source 3:0
// - same selector bits address fixed or floating view by operation
// - dual add/sub: difference 15:12, sum 11:8, X 7:4, Y 3:0
// - sum and difference share X and Y; each has own destination
// - mul with ALU: mul result 15:12, ALU result 11:8, 2-bit sources
// - restricted ALU X source picks registers 8 to 11
// - restricted ALU Y source picks registers 12 to 15
// - restricted multiplier X source picks registers 0 to 3
// - restricted multiplier Y source picks registers 4 to 7
// - floating ALU X and Y limited to 8-11 and 12-15
// - floating multiplier X and Y limited to 0-3 and 4-7
// - mul dual add/sub: diff 19:16, mul 15:12, sum 11:8, 2-bit sources
// - sum and difference use restricted ALU sources, multiplier its own
// - short compute: 7:4 is Y source and result, 3:0 is X source
// - 64-bit single function: result pair 11:8, sources 7:4 and 3:0
// - pair selector valid only when even; odd codes name nothing
`timescale 1ns/1ps
`default_nettype none
`include "compute_field_map.svh"
module compute_field_decode
(
	// clock, reset and enable; they only pace the checks
	input wire logic CLK,
	input wire logic RST_N,
	input wire logic CE,
	// instruction side
	input wire logic [19:0] FIELD,
	input wire compute_field_pkg::form_t FORM,
	input wire logic IS_FLOAT,
	// fixed-point view
	output logic [3:0] FIX_DEST_SEL,
	output logic [3:0] FIX_X_SRC,
	output logic [3:0] FIX_Y_SRC,
	output logic [3:0] FIX_ADD_DEST,
	output logic [3:0] FIX_SUB_DEST,
	output logic [3:0] FIX_MUL_DEST,
	output logic [3:0] FIX_MUL_X_SRC,
	output logic [3:0] FIX_MUL_Y_SRC,
	// floating-point view
	output logic [3:0] FLT_DEST_SEL,
	output logic [3:0] FLT_X_SRC,
	output logic [3:0] FLT_Y_SRC,
	output logic [3:0] FLT_ADD_DEST,
	output logic [3:0] FLT_SUB_DEST,
	output logic [3:0] FLT_MUL_DEST,
	output logic [3:0] FLT_MUL_X_SRC,
	output logic [3:0] FLT_MUL_Y_SRC,
	// 64-bit pairs
	output logic [3:0] DBL_DEST_PAIR,
	output logic [3:0] DBL_SRC1_PAIR,
	output logic [3:0] DBL_SRC2_PAIR,
	output logic PAIR_FAULT,
	// port enables
	output logic DEST_WR,
	output logic ADD_WR,
	output logic SUB_WR,
	output logic MUL_WR,
	output logic SRC_RD,
	output logic MUL_RD,
	output logic DBL_WR,
	output logic DBL_RD
);

	// ****************************************
	// helpers
	// ****************************************

	// widen a 2-bit restricted selector into its bank of four
	function automatic logic [3:0] bank(input logic [1:0] code,
		input logic [3:0] base);
		bank = base | {2'h0, code};
	endfunction

	// hand an index to one view, zero to the other
	function automatic logic [3:0] view(input logic [3:0] idx,
		input logic pick);
		view = pick ? idx : `IDX_ZERO;
	endfunction

	// ****************************************
	// form decode
	// ****************************************

	wire logic f_single = (FORM == compute_field_pkg::FORM_SINGLE);
	wire logic f_dual = (FORM == compute_field_pkg::FORM_DUAL);
	wire logic f_mul_alu = (FORM == compute_field_pkg::FORM_MUL_ALU);
	wire logic f_mul_dual = (FORM == compute_field_pkg::FORM_MUL_DUAL);
	wire logic f_short = (FORM == compute_field_pkg::FORM_SHORT);
	wire logic f_dbl = (FORM == compute_field_pkg::FORM_DBL);
	wire logic f_multi = f_mul_alu | f_mul_dual;

	// ****************************************
	// raw selectors
	// ****************************************

	wire logic [3:0] s_top = FIELD[`F_TOP_LSB +: `SEL_W];
	wire logic [3:0] s_mid = FIELD[`F_MID_LSB +: `SEL_W];
	wire logic [3:0] s_hi = FIELD[`F_HI_LSB +: `SEL_W];
	wire logic [3:0] s_x = FIELD[`F_X_LSB +: `SEL_W];
	wire logic [3:0] s_y = FIELD[`F_Y_LSB +: `SEL_W];

	// restricted banks, same for both views
	wire logic [3:0] r_mul_x =
		bank(FIELD[`RS_MUL_X_LSB +: `RSEL_W], `BASE_MUL_X);
	wire logic [3:0] r_mul_y =
		bank(FIELD[`RS_MUL_Y_LSB +: `RSEL_W], `BASE_MUL_Y);
	wire logic [3:0] r_alu_x =
		bank(FIELD[`RS_ALU_X_LSB +: `RSEL_W], `BASE_ALU_X);
	wire logic [3:0] r_alu_y =
		bank(FIELD[`RS_ALU_Y_LSB +: `RSEL_W], `BASE_ALU_Y);

	// single result: short compute reuses its Y selector
	wire logic [3:0] dest_idx = f_short ? s_x : s_hi;
	// ALU X source
	wire logic [3:0] x_idx = f_multi ? r_alu_x :
		(f_short ? s_y : s_x);
	// ALU Y source; short compute names it with the result
	wire logic [3:0] y_idx = f_multi ? r_alu_y :
		(f_short ? s_x : s_y);
	wire logic [3:0] add_idx = s_hi;
	wire logic [3:0] sub_idx = f_mul_dual ? s_top : s_mid;
	wire logic [3:0] mul_idx = s_mid;

	// ****************************************
	// 64-bit pairs
	// ****************************************

	wire logic [3:0] pd_reg;
	wire logic [3:0] p1_reg;
	wire logic [3:0] p2_reg;
	wire logic pd_ok;
	wire logic p1_ok;
	wire logic p2_ok;

	pair_select u_dest (.code(s_hi), .low_reg(pd_reg), .ok(pd_ok));
	pair_select u_src1 (.code(s_x), .low_reg(p1_reg), .ok(p1_ok));
	pair_select u_src2 (.code(s_y), .low_reg(p2_reg), .ok(p2_ok));

	// ****************************************
	// outputs, no storage on the path
	// ****************************************

	// a 64-bit form with an odd code names nothing; raise a fault
	assign PAIR_FAULT = f_dbl & ~(pd_ok & p1_ok & p2_ok);
	assign DBL_DEST_PAIR = f_dbl ? pd_reg : `IDX_ZERO;
	assign DBL_SRC1_PAIR = f_dbl ? p1_reg : `IDX_ZERO;
	assign DBL_SRC2_PAIR = f_dbl ? p2_reg : `IDX_ZERO;
	assign DBL_WR = f_dbl & pd_ok;
	assign DBL_RD = f_dbl & p1_ok & p2_ok;

	assign DEST_WR = f_single | f_short | f_mul_alu;
	assign ADD_WR = f_dual | f_mul_dual;
	assign SUB_WR = f_dual | f_mul_dual;
	assign MUL_WR = f_multi;
	assign SRC_RD = f_single | f_dual | f_short | f_multi;
	assign MUL_RD = f_multi;

	// the same bits feed whichever view the operation uses
	assign FIX_DEST_SEL = view(dest_idx, ~IS_FLOAT);
	assign FIX_X_SRC = view(x_idx, ~IS_FLOAT);
	assign FIX_Y_SRC = view(y_idx, ~IS_FLOAT);
	assign FIX_ADD_DEST = view(add_idx, ~IS_FLOAT);
	assign FIX_SUB_DEST = view(sub_idx, ~IS_FLOAT);
	assign FIX_MUL_DEST = view(mul_idx, ~IS_FLOAT);
	assign FIX_MUL_X_SRC = view(r_mul_x, ~IS_FLOAT);
	assign FIX_MUL_Y_SRC = view(r_mul_y, ~IS_FLOAT);
	assign FLT_DEST_SEL = view(dest_idx, IS_FLOAT);
	assign FLT_X_SRC = view(x_idx, IS_FLOAT);
	assign FLT_Y_SRC = view(y_idx, IS_FLOAT);
	assign FLT_ADD_DEST = view(add_idx, IS_FLOAT);
	assign FLT_SUB_DEST = view(sub_idx, IS_FLOAT);
	assign FLT_MUL_DEST = view(mul_idx, IS_FLOAT);
	assign FLT_MUL_X_SRC = view(r_mul_x, IS_FLOAT);
	assign FLT_MUL_Y_SRC = view(r_mul_y, IS_FLOAT);

	// ****************************************
	// checks
	// ****************************************

	// fixed view of one form, looked at only while enabled
	sequence s_fixed(compute_field_pkg::form_t fm);
		CE && FORM == fm && !IS_FLOAT;
	endsequence

	// floating view of one form
	sequence s_float(compute_field_pkg::form_t fm);
		CE && FORM == fm && IS_FLOAT;
	endsequence

	a_single_fields: assert property (
		@(posedge CLK) disable iff (!RST_N)
		s_fixed(compute_field_pkg::FORM_SINGLE) |-> DEST_WR &&
		FIX_DEST_SEL == FIELD[11:8] && FIX_X_SRC == FIELD[7:4] &&
		FIX_Y_SRC == FIELD[3:0])
		else $error("single computation selectors wrong");

	a_view_split: assert property (
		@(posedge CLK) disable iff (!RST_N)
		CE && IS_FLOAT |-> FIX_DEST_SEL == 4'h0 && FIX_X_SRC == 4'h0 &&
		FLT_DEST_SEL == dest_idx && FLT_Y_SRC == y_idx)
		else $error("floating view leaks into fixed view");

	a_flt_single: assert property (
		@(posedge CLK) disable iff (!RST_N)
		s_float(compute_field_pkg::FORM_SINGLE) |-> DEST_WR &&
		FLT_DEST_SEL == FIELD[11:8] && FLT_X_SRC == FIELD[7:4] &&
		FLT_Y_SRC == FIELD[3:0] && FIX_Y_SRC == 4'h0)
		else $error("single computation floating view wrong");

	a_dual_fields: assert property (
		@(posedge CLK) disable iff (!RST_N)
		s_fixed(compute_field_pkg::FORM_DUAL) |-> ADD_WR && SUB_WR &&
		FIX_SUB_DEST == FIELD[15:12] && FIX_ADD_DEST == FIELD[11:8] &&
		FIX_X_SRC == FIELD[7:4] && FIX_Y_SRC == FIELD[3:0])
		else $error("dual add/sub selectors wrong");

	a_dual_shared: assert property (
		@(posedge CLK) disable iff (!RST_N)
		s_float(compute_field_pkg::FORM_DUAL) |-> ADD_WR && SUB_WR &&
		FLT_SUB_DEST == FIELD[15:12] && FLT_ADD_DEST == FIELD[11:8] &&
		FLT_X_SRC == FIELD[7:4] && FLT_Y_SRC == FIELD[3:0])
		else $error("dual add/sub sources not shared");

	a_mul_alu_map: assert property (
		@(posedge CLK) disable iff (!RST_N)
		s_fixed(compute_field_pkg::FORM_MUL_ALU) |->
		FIX_MUL_DEST == FIELD[15:12] && FIX_DEST_SEL == FIELD[11:8] &&
		FIX_MUL_X_SRC == {2'h0, FIELD[7:6]} &&
		FIX_MUL_Y_SRC == {2'h1, FIELD[5:4]})
		else $error("multiply with ALU selectors wrong");

	a_alu_banks: assert property (
		@(posedge CLK) disable iff (!RST_N)
		CE && (f_multi) |-> x_idx == {2'h2, FIELD[3:2]} &&
		y_idx == {2'h3, FIELD[1:0]})
		else $error("restricted ALU source outside its bank");

	a_fix_mul_bank: assert property (
		@(posedge CLK) disable iff (!RST_N)
		CE && f_multi && !IS_FLOAT |->
		FIX_MUL_X_SRC == {2'h0, FIELD[7:6]} &&
		FIX_MUL_Y_SRC == {2'h1, FIELD[5:4]} && FLT_MUL_X_SRC == 4'h0)
		else $error("fixed multiplier source outside its bank");

	a_flt_alu_bank: assert property (
		@(posedge CLK) disable iff (!RST_N)
		CE && f_multi && IS_FLOAT |->
		FLT_X_SRC == {2'h2, FIELD[3:2]} && FLT_Y_SRC == {2'h3, FIELD[1:0]})
		else $error("floating ALU source outside its bank");

	a_flt_mul_bank: assert property (
		@(posedge CLK) disable iff (!RST_N)
		CE && f_multi && IS_FLOAT |-> FLT_MUL_X_SRC[3:2] == 2'h0 &&
		FLT_MUL_Y_SRC[3:2] == 2'h1 && FLT_X_SRC[3:2] == 2'h2 &&
		FLT_Y_SRC[3:2] == 2'h3)
		else $error("floating restricted source outside its bank");

	a_mul_dual_map: assert property (
		@(posedge CLK) disable iff (!RST_N)
		s_fixed(compute_field_pkg::FORM_MUL_DUAL) |->
		FIX_SUB_DEST == FIELD[19:16] && FIX_MUL_DEST == FIELD[15:12] &&
		FIX_ADD_DEST == FIELD[11:8] && MUL_RD && MUL_WR)
		else $error("mul dual add/sub selectors wrong");

	// both ALU results read the restricted pair, never the raw nibbles
	a_mul_dual_src: assert property (
		@(posedge CLK) disable iff (!RST_N)
		CE && f_mul_dual |-> SRC_RD && MUL_RD && !DEST_WR &&
		x_idx == {2'h2, FIELD[3:2]} && y_idx == {2'h3, FIELD[1:0]} &&
		r_mul_x == {2'h0, FIELD[7:6]} && r_mul_y == {2'h1, FIELD[5:4]})
		else $error("mul dual add/sub sources wrong");

	a_short_fields: assert property (
		@(posedge CLK) disable iff (!RST_N)
		s_fixed(compute_field_pkg::FORM_SHORT) |->
		FIX_DEST_SEL == FIELD[7:4] && FIX_Y_SRC == FIELD[7:4] &&
		FIX_X_SRC == FIELD[3:0])
		else $error("short compute selectors wrong");

	a_dbl_fields: assert property (
		@(posedge CLK) disable iff (!RST_N)
		CE && f_dbl |-> !SRC_RD && !DEST_WR &&
		DBL_DEST_PAIR == FIELD[11:8] && DBL_SRC1_PAIR == FIELD[7:4] &&
		DBL_SRC2_PAIR == FIELD[3:0])
		else $error("64-bit pair selectors wrong");

	// each port group drops only for its own odd code
	a_pair_odd: assert property (
		@(posedge CLK) disable iff (!RST_N)
		CE && f_dbl && (FIELD[8] || FIELD[4] || FIELD[0]) |->
		PAIR_FAULT && DBL_WR == !FIELD[8] &&
		DBL_RD == !(FIELD[4] || FIELD[0]))
		else $error("odd pair selector accepted");

	a_pair_even: assert property (
		@(posedge CLK) disable iff (!RST_N)
		CE && f_dbl && !FIELD[8] && !FIELD[4] && !FIELD[0] |->
		!PAIR_FAULT && DBL_WR && DBL_RD)
		else $error("even pair selector refused");

	a_same_cycle: assert property (
		@(posedge CLK) disable iff (!RST_N)
		CE && $changed(FIELD) && f_dbl |->
		DBL_DEST_PAIR == FIELD[11:8] && DBL_SRC1_PAIR == FIELD[7:4] &&
		DBL_SRC2_PAIR == FIELD[3:0])
		else $error("pair selectors lag the field");

endmodule
`default_nettype wire

// [bench/tb_top.sv]
// self-checking bench of the compute field decoder
`timescale 1ns/1ps
`default_nettype none
module tb_top;
	typedef struct packed {
		logic [75:0] es;
		logic [75:0] ms;
		logic [8:0] ef;
	} note_t;
	logic clk = 1'h0;
	logic rst_n = 1'h0;
	logic ce = 1'h0;
	logic [19:0] field = 20'h00000;
	logic is_float = 1'h0;
	compute_field_pkg::form_t form = compute_field_pkg::FORM_SINGLE;
	wire [75:0] sel;
	wire [8:0] flg;
	note_t q[$];
	note_t n_cur;
	int error_cnt = 0;
	int total_checks = 0;
	int cyc = 0;
	always #5 clk = ~clk;
	compute_field_decode dut_u (.CLK(clk), .RST_N(rst_n), .CE(ce),
		.FIELD(field), .FORM(form), .IS_FLOAT(is_float),
		.FIX_DEST_SEL(sel[75:72]), .FIX_X_SRC(sel[71:68]),
		.FIX_Y_SRC(sel[67:64]), .FIX_ADD_DEST(sel[63:60]),
		.FIX_SUB_DEST(sel[59:56]), .FIX_MUL_DEST(sel[55:52]),
		.FIX_MUL_X_SRC(sel[51:48]), .FIX_MUL_Y_SRC(sel[47:44]),
		.FLT_DEST_SEL(sel[43:40]), .FLT_X_SRC(sel[39:36]),
		.FLT_Y_SRC(sel[35:32]), .FLT_ADD_DEST(sel[31:28]),
		.FLT_SUB_DEST(sel[27:24]), .FLT_MUL_DEST(sel[23:20]),
		.FLT_MUL_X_SRC(sel[19:16]), .FLT_MUL_Y_SRC(sel[15:12]),
		.DBL_DEST_PAIR(sel[11:8]), .DBL_SRC1_PAIR(sel[7:4]),
		.DBL_SRC2_PAIR(sel[3:0]), .PAIR_FAULT(flg[8]), .DEST_WR(flg[7]),
		.ADD_WR(flg[6]), .SUB_WR(flg[5]), .MUL_WR(flg[4]), .SRC_RD(flg[3]),
		.MUL_RD(flg[2]), .DBL_WR(flg[1]), .DBL_RD(flg[0]));
	// ****************
	// reference model
	// ****************
	// nibbles 7..0: dest, x, y, add, sub, mul, mul x, mul y
	function automatic note_t model(logic [19:0] f, logic [5:0] k, logic fl);
		logic [7:0][3:0] v;
		logic [7:0] m;
		logic [31:0] am;
		logic [11:0] d;
		note_t n;
		v = '0;
		m = 8'h00;
		d = 12'h000;
		n = '0;
		case (k)
			6'h01:
			begin
				v[7:5] = f[11:0];
				m = 8'hE0;
				n.ef = 9'h088;
			end
			6'h02:
			begin
				v[6:5] = f[7:0];
				v[4:3] = {f[11:8], f[15:12]};
				m = 8'h78;
				n.ef = 9'h068;
			end
			6'h04:
			begin
				v[7] = f[11:8];
				v[2] = f[15:12];
				m = 8'hE7;
				n.ef = 9'h09C;
			end
			6'h08:
			begin
				v[4:2] = {f[11:8], f[19:16], f[15:12]};
				m = 8'h7F;
				n.ef = 9'h07C;
			end
			6'h10:
			begin
				v[7:5] = {f[7:4], f[3:0], f[7:4]};
				m = 8'hE0;
				n.ef = 9'h088;
			end
			6'h20:
			begin
				d = f[11:0];
				n.ef = {f[8] | f[4] | f[0], 6'h00, ~f[8], ~f[4] & ~f[0]};
			end
			default:
				n.ef = 9'h000;
		endcase
		// restricted banks for both multi-function forms
		if (k == 6'h04 || k == 6'h08)
		begin
			v[6:5] = {2'h2, f[3:2], 2'h3, f[1:0]};
			v[1:0] = {2'h0, f[7:6], 2'h1, f[5:4]};
		end
		for (int i = 0; i < 8; i++)
			am[i*4+:4] = {4{m[i]}};
		n.es = fl ? {32'h0, v, d} : {v, 32'h0, d};
		n.ms = fl ? {{32{|m}}, am, 12'hFFF} : {am, {32{|m}}, 12'hFFF};
		return n;
	endfunction
	// ****************
	// driver and checks
	// ****************
	task automatic apply(logic [19:0] f, logic [5:0] k, logic fl);
		@(posedge clk);
		#1;
		field = f;
		form = compute_field_pkg::form_t'(k);
		is_float = fl;
		ce = 1'($urandom_range(1, 0));
		q.push_back(model(f, k, fl));
	endtask
	task automatic chk_sel(logic [75:0] g, logic [75:0] e);
		total_checks++;
		if (g !== e)
		begin
			error_cnt++;
			$display("CHECK FAILED t=%0t sel got %h exp %h", $time, g, e);
		end
	endtask
	task automatic chk_flg(logic [8:0] g, logic [8:0] e);
		total_checks++;
		if (g !== e)
		begin
			error_cnt++;
			$display("CHECK FAILED t=%0t flags got %h exp %h", $time, g, e);
		end
	endtask
	task automatic finish_test();
		if (error_cnt == 0 && total_checks > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	// same-cycle answer: sampled mid-cycle after the drive
	always @(negedge clk)
	begin
		if (q.size() > 0)
		begin
			n_cur = q.pop_front();
			chk_sel(sel & n_cur.ms, n_cur.es & n_cur.ms);
			chk_flg(flg, n_cur.ef);
		end
	end
	always @(posedge clk)
	begin
		cyc++;
		if (cyc == 3000)
		begin
			error_cnt++;
			finish_test();
		end
	end
	initial
	begin
		logic [5:0] k;
		void'($urandom(34328));
		repeat (3) @(posedge clk);
		#1;
		rst_n = 1'h1;
		apply(20'h00321, 6'h01, 1'h0);
		apply(20'h00321, 6'h01, 1'h1);
		apply(20'h0AB1B, 6'h04, 1'h0);
		apply(20'h0AB1B, 6'h04, 1'h1);
		apply(20'h00053, 6'h10, 1'h0);
		apply(20'h9C5E4, 6'h08, 1'h1);
		apply(20'h0D7A6, 6'h02, 1'h0);
		apply(20'h00A4C, 6'h20, 1'h1);
		for (int i = 0; i < 16; i++)
			apply({8'h00, i[3:0], ~i[3:0], i[3:0] ^ 4'h1}, 6'h20,
				1'h1);
		for (int i = 0; i < 256; i++)
			apply({12'h5A3, i[7:0]}, i[0] ? 6'h04 : 6'h08,
				i[1]);
		apply(20'hFFFFF, 6'h00, 1'h0);
		apply(20'h12345, 6'h03, 1'h1);
		rst_n = 1'h0;
		apply(20'h6789A, 6'h3F, 1'h0);
		apply(20'h00321, 6'h01, 1'h0);
		rst_n = 1'h1;
		repeat (400)
		begin
			k = ($urandom % 8 < 6) ? 6'h01 << ($urandom % 6) : 6'($urandom);
			apply(20'($urandom), k, 1'($urandom));
		end
		repeat (2) @(posedge clk);
		finish_test();
	end
endmodule
`default_nettype wire
